// ### inc/ezsi_defs.vh
// How it works
// - Sa7 zero in two of last three
// - Status bit 5 shows live Sa7 state
// - Sa7 state change sets bit 1 flag
// - Status read clears both change flags
// - Excess-zero change sets bit 0 flag
// - Enable bit 1 gates Sa7 interrupt on irq_o
// - Enable bit 0 gates excess-zero interrupt on irq_o
//
// Purpose: constants for the Sa7 / excess-zero interrupt block
// Assumes: APB, one word per register
// Notes:   header holds definitions only
`ifndef EZSI_DEFS_VH
`define EZSI_DEFS_VH
`define EZSI_ADDR_W       4
`define EZSI_OFF_STATUS   4'h0
`define EZSI_OFF_ENABLE   4'h4
`define EZSI_OFF_IRQ_STAT 4'h8
`define EZSI_OFF_IRQ_MASK 4'hC
`define EZSI_BIT_SA7_ST   5
`define EZSI_BIT_SA7_CHG  1
`define EZSI_BIT_EXZ_CHG  0
`define EZSI_RST_BYTE     8'h00
`define EZSI_RST_2B       2'h0
`define EZSI_VOTE_MIN     2'h2
`define EZSI_EV_MSB       1
`define EZSI_HIST_RST     3'h0
`endif

// ### logic/ezsi_sa7_vote.v
// Purpose: two-of-three vote on received Sa7 samples
// Assumes: sample strobe on mclk_i, from framer logic
// Notes:   output is registered
`timescale 1ns/1ps
`include "ezsi_defs.vh"
module ezsi_sa7_vote
(
  // Clock and reset
  input  wire       mclk_i,
  input  wire       arst_n_i,
  // Sample
  input  wire       sa7_vld_i,
  input  wire       sa7_bit_i,
  // Result
  output reg        sa7_zero_o
);
  reg  [2:0] hist_r;
  wire [2:0] hist_nxt;
  wire [1:0] zeros;

  assign hist_nxt = {hist_r[1:0], ~sa7_bit_i};
  assign zeros = {1'b0, hist_nxt[0]} + {1'b0, hist_nxt[1]}
               + {1'b0, hist_nxt[2]};

  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      hist_r     <= `EZSI_HIST_RST;
      sa7_zero_o <= 1'b0;
    end
    else if (sa7_vld_i)
    begin
      hist_r     <= hist_nxt;
      sa7_zero_o <= (zeros >= `EZSI_VOTE_MIN);
    end
  end
endmodule // ezsi_sa7_vote

// ### logic/ezsi_top.v
// Purpose: Sa7-zero and excess-zero change interrupts with APB access
// Assumes: framer strobes on mclk_i; pins pass two flops
// Notes:   status read clears change flags
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "ezsi_defs.vh"
module ezsi_top
(
  // Clock and reset
  input  wire        mclk_i,
  input  wire        arst_n_i,
  // APB
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [31:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  // Framer side
  input  wire        sa7_vld_i,
  input  wire        sa7_bit_i,
  input  wire        excess_zero_i,
  // Interrupts
  output reg         irq_o,
  output reg         host_irq_o
);
  ////////////////////////////////////////////////////////////////////
  reg        exz_s1_r;
  reg        exz_s2_r;
  reg        exz_d_r;
  reg        sa7_d_r;
  wire       sa7_zero_state;
  reg        sa7_zero_change_flag;
  reg        excess_zero_change_flag;
  reg        sa7_zero_change_irq_en;
  reg        excess_zero_change_irq_en;
  reg  [1:0] ev_stat_r;
  reg  [1:0] ev_mask_r;
  reg  [31:0] rd_nxt;
  wire [`EZSI_ADDR_W-1:0] a;
  wire       acc;
  wire       wr;
  wire       rd;
  wire       hit;
  wire       rd_stat;
  wire       wr_en;
  wire       wr_mask;
  wire       wr_stat;
  wire       sa7_chg;
  wire       exz_chg;
  wire [1:0] ev;

  assign a   = paddr_i[`EZSI_ADDR_W-1:0];
  assign acc = psel_i & penable_i & ~pready_o;
  assign wr  = acc & pwrite_i;
  assign rd  = acc & ~pwrite_i;
  assign hit = (paddr_i[31:`EZSI_ADDR_W] == 28'h0000000);
  // One decode per register access for the flag and register processes; the read mux decodes a in its own case
  assign rd_stat = rd & hit & (a == `EZSI_OFF_STATUS);
  assign wr_en   = wr & hit & (a == `EZSI_OFF_ENABLE);
  assign wr_mask = wr & hit & (a == `EZSI_OFF_IRQ_MASK);
  assign wr_stat = wr & hit & (a == `EZSI_OFF_IRQ_STAT);

  ezsi_sa7_vote u_vote
  (
    .mclk_i     (mclk_i),
    .arst_n_i   (arst_n_i),
    .sa7_vld_i  (sa7_vld_i),
    .sa7_bit_i  (sa7_bit_i),
    .sa7_zero_o (sa7_zero_state)
  );

  ////////////////////////////////////////////////////////////////////
  // Edge detection; excess-zero level is a pin, so synchronise
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      exz_s1_r <= 1'b0;
      exz_s2_r <= 1'b0;
      exz_d_r  <= 1'b0;
      sa7_d_r  <= 1'b0;
    end
    else
    begin
      exz_s1_r <= excess_zero_i;
      exz_s2_r <= exz_s1_r;
      exz_d_r  <= exz_s2_r;
      sa7_d_r  <= sa7_zero_state;
    end
  end

  assign sa7_chg = sa7_zero_state ^ sa7_d_r;
  assign exz_chg = exz_s2_r ^ exz_d_r;
  assign ev      = {sa7_chg, exz_chg};

  ////////////////////////////////////////////////////////////////////
  // Flags: a new event wins over the read clear
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sa7_zero_change_flag    <= 1'b0;
      excess_zero_change_flag <= 1'b0;
    end
    else
    begin
      if (sa7_chg)
        sa7_zero_change_flag <= 1'b1;
      else if (rd_stat)
        sa7_zero_change_flag <= 1'b0;
      if (exz_chg)
        excess_zero_change_flag <= 1'b1;
      else if (rd_stat)
        excess_zero_change_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Writable registers and sticky event status
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sa7_zero_change_irq_en    <= 1'b0;
      excess_zero_change_irq_en <= 1'b0;
      ev_stat_r                 <= `EZSI_RST_2B;
      ev_mask_r                 <= `EZSI_RST_2B;
    end
    else
    begin
      if (wr_en)
      begin
        sa7_zero_change_irq_en    <= pwdata_i[`EZSI_BIT_SA7_CHG];
        excess_zero_change_irq_en <= pwdata_i[`EZSI_BIT_EXZ_CHG];
      end
      if (wr_mask)
        ev_mask_r <= pwdata_i[`EZSI_EV_MSB:0];
      if (wr_stat)
        ev_stat_r <= (ev_stat_r & ~pwdata_i[`EZSI_EV_MSB:0]) | ev;
      else
        ev_stat_r <= ev_stat_r | ev;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read mux; reserved bits read zero
  always @*
  begin
    rd_nxt = 32'h00000000;
    case (a)
      `EZSI_OFF_STATUS:
      begin
        rd_nxt[`EZSI_BIT_SA7_ST]  = sa7_zero_state;
        rd_nxt[`EZSI_BIT_SA7_CHG] = sa7_zero_change_flag;
        rd_nxt[`EZSI_BIT_EXZ_CHG] = excess_zero_change_flag;
      end
      `EZSI_OFF_ENABLE:
      begin
        rd_nxt[`EZSI_BIT_SA7_CHG] = sa7_zero_change_irq_en;
        rd_nxt[`EZSI_BIT_EXZ_CHG] = excess_zero_change_irq_en;
      end
      `EZSI_OFF_IRQ_STAT: rd_nxt[`EZSI_EV_MSB:0] = ev_stat_r;
      `EZSI_OFF_IRQ_MASK: rd_nxt[`EZSI_EV_MSB:0] = ev_mask_r;
      default:            rd_nxt = 32'h00000000;
    endcase
    if (!hit)
      rd_nxt = 32'h00000000;
  end

  ////////////////////////////////////////////////////////////////////
  // APB answer one cycle after access starts; outputs registered
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      prdata_o   <= 32'h00000000;
      pready_o   <= 1'b0;
      pslverr_o  <= 1'b0;
      irq_o      <= 1'b0;
      host_irq_o <= 1'b0;
    end
    else
    begin
      pready_o  <= acc;
      pslverr_o <= acc & ~hit;
      if (rd)
        prdata_o <= rd_nxt;
      irq_o <= (sa7_zero_change_flag & sa7_zero_change_irq_en)
             | (excess_zero_change_flag
                & excess_zero_change_irq_en);
      host_irq_o <= |(ev_stat_r & ev_mask_r);
    end
  end
endmodule // ezsi_top

// ### sim/ezsi_properties.sv
// Purpose: ezsi_top port checks
// Assumes: APB write lands at take edge
// Notes:   shadows enable and Sa7 history
`timescale 1ns/1ps
module ezsi_props
(
  // Clock, reset, APB
  input wire logic        mclk_i, arst_n_i, psel_i, penable_i, pwrite_i,
  input wire logic [31:0] paddr_i, pwdata_i, prdata_o,
  input wire logic        pready_o,
  // Framer and irq
  input wire logic        sa7_vld_i, sa7_bit_i, excess_zero_i, irq_o
);
  reg  [2:0] h_r;
  reg  [1:0] en_r;
  wire       tk  = psel_i & penable_i & !pready_o;
  wire       rd0 = psel_i & !pwrite_i & paddr_i == 32'h0;
  wire [2:0] hn  = {h_r[1:0], sa7_bit_i};
  function vt(input [2:0] x);
    vt = ~x[0] & ~x[1] | ~x[0] & ~x[2] | ~x[1] & ~x[2];
  endfunction
  // History starts all ones, so no zero state
  always @(posedge mclk_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      h_r  <= 3'h7;
      en_r <= 2'h0;
    end
    else
    begin
      if (sa7_vld_i)
        h_r <= hn;
      if (tk & pwrite_i & paddr_i == 32'h4)
        en_r <= pwdata_i[1:0];
    end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  chk_vote_state:
    assert property (pready_o & rd0 |-> prdata_o[5] == vt(h_r))
    else $error("state bit wrong");
  chk_status_resv:
    assert property (pready_o & rd0 |-> prdata_o[4:2] == 3'h0)
    else $error("reserved bits set");
  chk_sa7_change:
    assert property (sa7_vld_i & vt(hn) != vt(h_r) & en_r[1]
      |-> ##[2:4] irq_o) else $error("no sa7 irq");
  chk_rd_clear:
    assert property (tk & rd0 |-> ##2 !irq_o) else $error("no clear");
  chk_exz_change:
    assert property ($changed(excess_zero_i) & en_r[0] |-> ##[3:6] irq_o)
    else $error("no exz irq");
  chk_en_gate:
    assert property (en_r == 2'h0 ##1 en_r == 2'h0 |-> !irq_o)
    else $error("irq while disabled");
  chk_irq_reset:
    assert property ($rose(arst_n_i) |-> !irq_o) else $error("irq at reset");
  chk_irq_cause:
    assert property (irq_o |-> $past(en_r) != 2'h0)
    else $error("irq without enable");
endmodule // ezsi_props
bind ezsi_top ezsi_props u_chk (.*);

// ### sim/tb_top.sv
// Purpose: ezsi_top bench
// Assumes: one APB wait state
// Notes:   gaps keep events off reads
`timescale 1ns/1ps
module tb_top;
  localparam RD = 1'h0;
  localparam WR = 1'h1;
  reg         mclk_i = 1'h0, arst_n_i = 1'h0, ps = 1'h0, pe = 1'h0;
  reg         pw = 1'h0, vl = 1'h0, sb = 1'h1, ez = 1'h0;
  reg  [31:0] pa = 32'h0, pd = 32'h0;
  wire [31:0] rd;
  wire        rdy, er, irq, hq;
  integer     error_cnt = 0, n_checks = 0;
  ezsi_top uut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .psel_i(ps),
    .penable_i(pe), .pwrite_i(pw), .paddr_i(pa), .pwdata_i(pd),
    .prdata_o(rd), .pready_o(rdy), .pslverr_o(er), .sa7_vld_i(vl),
    .sa7_bit_i(sb), .excess_zero_i(ez), .irq_o(irq), .host_irq_o(hq));
  task chk(input [32:0] s, e);
    n_checks = n_checks + 1;
    if (s !== e)
    begin
      error_cnt = error_cnt + 1;
      $display("unexpected %0t %h %h", $time, s, e);
    end
  endtask
  // Writes send v, reads expect {pslverr, prdata} == v
  task bus(input w, input [31:0] a, input [32:0] v);
    @(posedge mclk_i);
    ps <= 1'h1;
    pw <= w;
    pa <= a;
    pd <= v[31:0];
    @(posedge mclk_i);
    pe <= 1'h1;
    @(posedge mclk_i);
    while (rdy !== 1'h1)
      @(posedge mclk_i);
    if (!w)
      chk({er, rd}, v);
    ps <= 1'h0;
    pe <= 1'h0;
  endtask
  task s7(input b);
    @(posedge mclk_i);
    vl <= 1'h1;
    sb <= b;
    @(posedge mclk_i);
    vl <= 1'h0;
    repeat (4) @(posedge mclk_i);
  endtask
  task ezp(input b);
    @(posedge mclk_i);
    ez <= b;
    repeat (8) @(posedge mclk_i);
  endtask
  task end_of_test;
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial forever #12.5 mclk_i = ~mclk_i;
  initial
  begin
    #20000;
    error_cnt = error_cnt + 1;
    end_of_test;
  end
  initial
  begin
    repeat (4) @(posedge mclk_i);
    arst_n_i <= 1'h1;
    bus(RD, 32'h0, 33'h0);
    bus(RD, 32'h4, 33'h0);
    bus(WR, 32'h4, 33'h3);
    bus(RD, 32'h4, 33'h3);
    s7(1'h0);
    s7(1'h0);
    chk(irq, 33'h1);
    bus(RD, 32'h0, 33'h22);
    bus(RD, 32'h0, 33'h20);
    chk(irq, 33'h0);
    s7(1'h1);
    bus(RD, 32'h0, 33'h20);
    s7(1'h1);
    bus(RD, 32'h0, 33'h2);
    ezp(1'h1);
    bus(RD, 32'h0, 33'h1);
    ezp(1'h0);
    chk(irq, 33'h1);
    bus(RD, 32'h0, 33'h1);
    bus(WR, 32'h4, 33'h0);
    bus(WR, 32'h14, 33'h3);
    bus(RD, 32'h4, 33'h0);
    bus(WR, 32'hC, 33'h3);
    bus(RD, 32'hC, 33'h3);
    ezp(1'h1);
    chk(irq, 33'h0);
    chk(hq, 33'h1);
    bus(RD, 32'h8, 33'h3);
    bus(WR, 32'h8, 33'h3);
    bus(RD, 32'h8, 33'h0);
    chk(hq, 33'h0);
    bus(RD, 32'h10, 33'h100000000);
    bus(RD, 32'h0, 33'h1);
    end_of_test;
  end
endmodule // tb_top
